// File: rtl/mic_checker.sv
// Update image checker: walks the image word stream and reports pass or fail
`timescale 1ns/1ps
`default_nettype none
module mic_checker
  import mic_pkg::*;
#(
  parameter int unsigned W     = WORD_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Image word stream
  input  wire logic [W-1:0] img_data,
  input  wire logic         img_valid,
  output logic              img_ready,
  // Control
  input  wire logic         start,
  // Identification of this processor
  input  wire logic [31:0]  proc_sig,
  input  wire logic [2:0]   plat_id,
  // Result
  output logic              busy,
  output logic              done,
  output logic              pass,
  output logic              err_sum,
  output logic              err_sig,
  output logic              err_plat,
  output logic              err_size
);
  mic_state_t   st_r, st_nxt;         // Controller state
  logic [31:0]  addr_r, addr_nxt;     // Byte offset of current word
  logic [31:0]  pl_r, pl_nxt;         // Payload length in bytes
  logic [31:0]  tot_r, tot_nxt;       // Total size in bytes
  logic [31:0]  psig_r, psig_nxt;     // Primary signature
  logic [31:0]  pchk_r, pchk_nxt;     // Primary checksum word
  logic [31:0]  pflg_r, pflg_nxt;     // Primary flags
  logic [31:0]  cnt_r, cnt_nxt;       // Extended entry count
  logic [31:0]  idx_r, idx_nxt;       // Entries seen so far
  logic [1:0]   ph_r, ph_nxt;         // Word within entry
  logic [31:0]  esig_r, esig_nxt;     // Entry signature
  logic [31:0]  eflg_r, eflg_nxt;     // Entry flags
  logic         dbad_r, dbad_nxt;     // Data size not word aligned
  logic         phit_r, phit_nxt;     // Primary signature matched
  logic         xsig_r, xsig_nxt;     // Some entry signature matched
  logic         xplt_r, xplt_nxt;     // Matched entry has our platform
  logic         ebad_r, ebad_nxt;     // Some entry checksum wrong
  logic         done_r, done_nxt;
  logic         pass_r, pass_nxt;
  logic         esum_r, esum_nxt;
  logic         esig_fail_r, esig_fail_nxt;
  logic         eplt_r, eplt_nxt;
  logic         esz_r, esz_nxt;
  logic         busy_r;

  // FIFO drain side and sums
  logic [W-1:0] wd;
  logic         f_valid, f_ready, pop, clr;
  logic [W-1:0] whole_sum, prim_sum, x_sum;
  logic [31:0]  base_x, ent_sum, whole_fin, x_fin;
  logic         in_prim, in_ent, fin, abort, x_present, sig_ok, plat_ok;
  logic [7:0]   pf8, ef8;

  mic_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_data   (img_data),
    .in_valid  (img_valid),
    .in_ready  (img_ready),
    .out_data  (wd),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // Checker stalls while idle, so a waiting image backs up into the FIFO
  assign f_ready = st_r == MIC_RUN;
  assign pop     = f_ready && f_valid;
  assign clr     = st_r == MIC_IDLE && start;

  // Primary region sum feeds the per-entry checksum
  mic_sum #(.W(W)) u_whole (.mclk(mclk), .rstn(rstn), .clr(clr),
    .add(pop), .word(wd), .sum_r(whole_sum));
  mic_sum #(.W(W)) u_prim (.mclk(mclk), .rstn(rstn), .clr(clr),
    .add(pop && in_prim), .word(wd), .sum_r(prim_sum));
  mic_sum #(.W(W)) u_ext (.mclk(mclk), .rstn(rstn), .clr(clr),
    .add(pop && !in_prim), .word(wd), .sum_r(x_sum));

  // Region decode from the running byte offset
  always_comb
  begin
    base_x    = pl_r + OFS_DATA;
    in_prim   = addr_r < OFS_DATA || addr_r < base_x;
    in_ent    = !in_prim && addr_r >= base_x + XOFS_ENT && idx_r < cnt_r;
    x_present = tot_r > base_x;
    whole_fin = whole_sum + wd;
    x_fin     = x_sum + wd;
    pf8       = pflg_r[FLAG_BITS-1:0];
    ef8       = eflg_r[FLAG_BITS-1:0];
    // Replace primary signature, flags and checksum by the entry's
    ent_sum   = prim_sum - psig_r - pflg_r - pchk_r + esig_r + eflg_r + wd;
    // Malformed sizes stop the walk right after the total size word
    abort     = pop && addr_r == OFS_TSIZE &&
                ((wd & SIZE_MASK) != '0 || dbad_r || wd < base_x);
    fin       = abort || (pop && addr_r > OFS_TSIZE && addr_r + WORD_BYTES == tot_r);
  end

  // Field capture and entry walk
  always_comb
  begin
    st_nxt   = st_r;
    addr_nxt = addr_r;
    pl_nxt   = pl_r;
    tot_nxt  = tot_r;
    psig_nxt = psig_r;
    pchk_nxt = pchk_r;
    pflg_nxt = pflg_r;
    cnt_nxt  = cnt_r;
    idx_nxt  = idx_r;
    ph_nxt   = ph_r;
    esig_nxt = esig_r;
    eflg_nxt = eflg_r;
    dbad_nxt = dbad_r;
    phit_nxt = phit_r;
    xsig_nxt = xsig_r;
    xplt_nxt = xplt_r;
    ebad_nxt = ebad_r;
    if (clr)
    begin
      // Fresh image: forget the walk state, sizes and count from the last one; captured signature, checksum, flag and entry words are left to be overwritten
      st_nxt   = MIC_RUN;
      addr_nxt = '0;
      pl_nxt   = '0;
      tot_nxt  = '0;
      cnt_nxt  = '0;
      idx_nxt  = '0;
      ph_nxt   = PH_SIG;
      dbad_nxt = 1'b0;
      phit_nxt = 1'b0;
      xsig_nxt = 1'b0;
      xplt_nxt = 1'b0;
      ebad_nxt = 1'b0;
    end
    else if (pop)
    begin
      addr_nxt = addr_r + WORD_BYTES;
      // Reserved header words fall through every case untouched
      case (addr_r)
        OFS_SIG:
        begin
          psig_nxt = wd;
          phit_nxt = wd == proc_sig;
        end
        OFS_CHK:   pchk_nxt = wd;
        OFS_FLAGS: pflg_nxt = wd;
        OFS_DSIZE:
        begin
          pl_nxt   = (wd == '0) ? DEF_DSIZE : wd;
          dbad_nxt = wd[1:0] != 2'h0;
        end
        OFS_TSIZE: tot_nxt = wd;
        default:
        begin
          if (!in_prim && addr_r == base_x + XOFS_CNT)
            cnt_nxt = wd;
        end
      endcase
      if (in_ent)
      begin
        case (ph_r)
          PH_SIG:
          begin
            esig_nxt = wd;
            ph_nxt   = PH_FLAGS;
          end
          PH_FLAGS:
          begin
            eflg_nxt = wd;
            ph_nxt   = PH_CHK;
          end
          PH_CHK:
          begin
            ph_nxt  = PH_SIG;
            idx_nxt = idx_r + 32'h1;
            if (ent_sum != '0)
              ebad_nxt = 1'b1;
            // Entries are only searched when the primary missed
            if (!phit_r && esig_r == proc_sig)
            begin
              xsig_nxt = 1'b1;
              if (ef8[plat_id])
                xplt_nxt = 1'b1;
            end
          end
          default: ph_nxt = PH_SIG;
        endcase
      end
      if (fin)
        st_nxt = MIC_IDLE;
    end
  end

  // Verdict on the last word, using this cycle's entry result
  always_comb
  begin
    done_nxt      = fin;
    pass_nxt      = 1'b0;
    esum_nxt      = 1'b0;
    esig_fail_nxt = 1'b0;
    eplt_nxt      = 1'b0;
    esz_nxt       = 1'b0;
    sig_ok        = phit_r || (x_present && xsig_nxt);
    plat_ok       = phit_r ? pf8[plat_id] : xplt_nxt;
    if (abort)
      esz_nxt = 1'b1;
    else if (fin)
    begin
      // Table must hold its header and every counted entry
      esz_nxt       = x_present && (tot_r < base_x + XOFS_ENT || idx_nxt < cnt_r);
      esum_nxt      = whole_fin != '0 ||
                      (x_present && (x_fin != '0 || ebad_nxt));
      esig_fail_nxt = !sig_ok;
      eplt_nxt      = sig_ok && !plat_ok;
      pass_nxt      = !esz_nxt && !esum_nxt && sig_ok && plat_ok;
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r        <= MIC_IDLE;
      addr_r      <= '0;
      pl_r        <= '0;
      tot_r       <= '0;
      psig_r      <= '0;
      pchk_r      <= '0;
      pflg_r      <= '0;
      cnt_r       <= '0;
      idx_r       <= '0;
      ph_r        <= PH_SIG;
      esig_r      <= '0;
      eflg_r      <= '0;
      dbad_r      <= 1'b0;
      phit_r      <= 1'b0;
      xsig_r      <= 1'b0;
      xplt_r      <= 1'b0;
      ebad_r      <= 1'b0;
      done_r      <= 1'b0;
      pass_r      <= 1'b0;
      esum_r      <= 1'b0;
      esig_fail_r <= 1'b0;
      eplt_r      <= 1'b0;
      esz_r       <= 1'b0;
      busy_r      <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      addr_r      <= addr_nxt;
      pl_r        <= pl_nxt;
      tot_r       <= tot_nxt;
      psig_r      <= psig_nxt;
      pchk_r      <= pchk_nxt;
      pflg_r      <= pflg_nxt;
      cnt_r       <= cnt_nxt;
      idx_r       <= idx_nxt;
      ph_r        <= ph_nxt;
      esig_r      <= esig_nxt;
      eflg_r      <= eflg_nxt;
      dbad_r      <= dbad_nxt;
      phit_r      <= phit_nxt;
      xsig_r      <= xsig_nxt;
      xplt_r      <= xplt_nxt;
      ebad_r      <= ebad_nxt;
      done_r      <= done_nxt;
      // Verdict flags hold until the next verdict
      if (done_nxt)
      begin
        pass_r      <= pass_nxt;
        esum_r      <= esum_nxt;
        esig_fail_r <= esig_fail_nxt;
        eplt_r      <= eplt_nxt;
        esz_r       <= esz_nxt;
      end
      busy_r      <= st_nxt == MIC_RUN;
    end
  end

  assign busy     = busy_r;
  assign done     = done_r;
  assign pass     = pass_r;
  assign err_sum  = esum_r;
  assign err_sig  = esig_fail_r;
  assign err_plat = eplt_r;
  assign err_size = esz_r;

  // Checks on the verdict and the field capture
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_last_word;
    fin && !abort;
  endsequence

  property p_done_pulse;
    done_r |=> !done_r;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held");

  property p_pass_excl;
    done_r && pass_r |-> !(esum_r || esig_fail_r || eplt_r || esz_r);
  endproperty
  a_pass_excl: assert property (p_pass_excl) else $error("pass with fail");

  property p_size_align;
    pop && addr_r == OFS_TSIZE && wd[9:0] != 10'h0 |=> done_r && esz_r && !pass_r;
  endproperty
  a_size_align: assert property (p_size_align) else $error("size not flagged");

  property p_zero_dsize;
    pop && addr_r == OFS_DSIZE && wd == '0 |=> pl_r == DEF_DSIZE;
  endproperty
  a_zero_dsize: assert property (p_zero_dsize) else $error("default size");

  property p_whole_sum;
    s_last_word and (whole_fin != '0) |=> done_r && esum_r && !pass_r;
  endproperty
  a_whole_sum: assert property (p_whole_sum) else $error("image sum");

  property p_ext_sum;
    s_last_word and (x_present && x_fin != '0) |=> ##0 esum_r ##1 !done_r;
  endproperty
  a_ext_sum: assert property (p_ext_sum) else $error("table sum");

  property p_sig_cap;
    pop && addr_r == OFS_SIG && wd == proc_sig |=> phit_r;
  endproperty
  a_sig_cap: assert property (p_sig_cap) else $error("sig capture");

  property p_plat;
    s_last_word and (phit_r && !pf8[plat_id]) |=> err_plat && !pass;
  endproperty
  a_plat: assert property (p_plat) else $error("platform miss");

  property p_prim_first;
    s_last_word and phit_r |=> !esig_fail_r;
  endproperty
  a_prim_first: assert property (p_prim_first) else $error("primary hit lost");

  property p_rsv_ignored;
    pop && addr_r >= OFS_RSV && addr_r < OFS_RSV + RSV_BYTES |=>
      $stable(pl_r) && $stable(tot_r) && $stable(cnt_r) && $stable(phit_r);
  endproperty
  a_rsv_ignored: assert property (p_rsv_ignored) else $error("reserved used");
endmodule
`default_nettype wire

// File: rtl/mic_pkg.sv
// Package: layout offsets, sizes and state codes of the update image checker
package mic_pkg;
  // Data path width, FIFO depth and flag field width
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FLAG_BITS   = 8;
  // Header byte offsets
  localparam logic [31:0] OFS_SIG     = 32'h0000_000c;
  localparam logic [31:0] OFS_CHK     = 32'h0000_0010;
  localparam logic [31:0] OFS_FLAGS   = 32'h0000_0018;
  localparam logic [31:0] OFS_DSIZE   = 32'h0000_001c;
  localparam logic [31:0] OFS_TSIZE   = 32'h0000_0020;
  localparam logic [31:0] OFS_RSV     = 32'h0000_0024;
  localparam logic [31:0] RSV_BYTES   = 32'h0000_000c;
  localparam logic [31:0] OFS_DATA    = 32'h0000_0030;
  // Payload size used when the data size word is zero
  localparam logic [31:0] DEF_DSIZE   = 32'h0000_07d0;
  // Offsets relative to the end of the payload region, then entry and word sizes
  localparam logic [31:0] XOFS_CNT    = 32'h0000_0000;
  localparam logic [31:0] XOFS_ENT    = 32'h0000_0014;
  localparam logic [31:0] ENT_BYTES   = 32'h0000_000c;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  // Total size must have these low bits clear, so it is a multiple of 1024 bytes
  localparam logic [31:0] SIZE_MASK   = 32'h0000_03ff;
  // Entry phase codes
  localparam logic [1:0]  PH_SIG      = 2'h0;
  localparam logic [1:0]  PH_FLAGS    = 2'h1;
  localparam logic [1:0]  PH_CHK      = 2'h2;
  // Controller states
  typedef enum logic [0:0] {
    MIC_IDLE = 1'b0,
    MIC_RUN  = 1'b1
  } mic_state_t;
endpackage

// File: rtl/mic_fifo.sv
// Word FIFO with valid and ready on both sides, sitting ahead of the checker
`timescale 1ns/1ps
`default_nettype none
module mic_fifo
  import mic_pkg::*;
#(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 16
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];       // Storage
  logic [AW-1:0] wp_r, wp_nxt;      // Write pointer
  logic [AW-1:0] rp_r, rp_nxt;      // Read pointer
  logic [CW-1:0] cnt_r, cnt_nxt;    // Fill level
  logic          rdy_r, rdy_nxt;    // Registered room flag
  logic          push, pop;

  // Pointer and level update
  always_comb
  begin
    push    = in_valid && rdy_r;
    pop     = out_ready && (cnt_r != '0);
    wp_nxt  = push ? wp_r + AW'(1) : wp_r;
    rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + CW'(1);
    else if (pop && !push)
      cnt_nxt = cnt_r - CW'(1);
    // Ready is registered from the next level, so from the first edge after reset it matches the current level and never lies about room
    rdy_nxt = cnt_nxt != FULL_CNT;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // Storage carries no reset; only valid words are ever read
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  assign in_ready  = rdy_r;
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
endmodule
`default_nettype wire

// File: rtl/mic_sum.sv
// Wrapping word accumulator used for the image, primary and table sums
`timescale 1ns/1ps
`default_nettype none
module mic_sum
  import mic_pkg::*;
#(
  parameter int unsigned W = 32
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Control and data
  input  wire logic         clr,
  input  wire logic         add,
  input  wire logic [W-1:0] word,
  // Running sum
  output logic [W-1:0]      sum_r
);
  logic [W-1:0] sum_nxt;

  // Carries out of the top bit are dropped on purpose
  always_comb
  begin
    sum_nxt = sum_r;
    if (clr)
      sum_nxt = '0;
    else if (add)
      sum_nxt = sum_r + word;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sum_r <= '0;
    else
      sum_r <= sum_nxt;
  end
endmodule
`default_nettype wire

// File: dv/mic_loader_model.sv
// Loader model: streams image words into the checker with valid and ready
`timescale 1ns/1ps
`default_nettype none
module mic_loader_model
(
  // Clock
  input  wire logic   mclk,
  // Word stream towards the checker
  output logic [31:0] img_data,
  output logic        img_valid,
  input  wire logic   img_ready
);
  logic [31:0] mem [0:1023];  // Image words, byte offset 0 first

  // Idle bus at time zero
  initial
  begin
    img_data = 32'h0;
    img_valid = 1'b0;
  end

  // Send n words; a gap every stall words keeps the buffer from staying full
  task automatic send(input int n, input int stall);
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk);
      // Gap: released data shows the inverse, not a stale word
      if (stall != 0 && i % stall == stall - 1)
      begin
        img_valid = 1'b0;
        img_data = ~img_data;
        @(negedge mclk);
      end
      img_valid = 1'b1;
      img_data = mem[i];
      // Ready is registered, so its value now holds at the next rising edge
      while (img_ready !== 1'b1)
        @(negedge mclk);
    end
    @(negedge mclk);
    img_valid = 1'b0;
    img_data = ~img_data;
  endtask
endmodule
`default_nettype wire

// File: dv/test_microcode_image_checker.sv
// Testbench: builds update images, streams them and judges the verdict flags
`timescale 1ns/1ps
`default_nettype none
module test_microcode_image_checker;
  import mic_pkg::*;
  logic        mclk;        // 20 MHz clock
  logic        rstn;        // Active low reset
  logic [31:0] img_data;    // Stream word
  logic        img_valid;   // Stream valid
  logic        img_ready;   // Buffer has room
  logic        start;       // Begin an image
  logic [31:0] proc_sig;    // Signature to match
  logic [2:0]  plat_id;     // Platform bit select
  logic        busy;
  logic        done;
  logic        pass;
  logic        err_sum;
  logic        err_sig;
  logic        err_plat;
  logic        err_size;
  logic [31:0] m [0:1023];  // Image under construction
  int          n_mismatch;
  int          tests_run;
  localparam logic [31:0] PS = 32'h000a_0f65;  // Packed id of this processor

  mic_checker mic_checker_inst (.mclk(mclk), .rstn(rstn), .img_data(img_data),
    .img_valid(img_valid), .img_ready(img_ready), .start(start), .proc_sig(proc_sig),
    .plat_id(plat_id), .busy(busy), .done(done), .pass(pass), .err_sum(err_sum),
    .err_sig(err_sig), .err_plat(err_plat), .err_size(err_size));
  mic_loader_model mic_loader_model_inst (.mclk(mclk), .img_data(img_data),
    .img_valid(img_valid), .img_ready(img_ready));

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Build an image whose sums all come out zero; entry hit carries PS
  task automatic build(input logic [31:0] psig, input logic [31:0] pfl, input logic [31:0] dw,
                       input logic [31:0] tot, input int cnt, input int hit,
                       input logic [31:0] efl);
    int          pl;
    int          t;
    logic [31:0] s;
    logic [31:0] es;
    pl = (dw == 32'h0) ? 2000 : int'(dw);
    t = (pl + 48) / 4;
    // Filler also lands in the reserved header words
    for (int i = 0; i < 1024; i++)
      m[i] = (i < int'(tot) / 4) ? (i * 32'h0001_0003) ^ 32'h5a5a_0000 : 32'h0;
    m[0] = 32'h1;
    m[3] = psig;
    m[4] = 32'h0;
    m[6] = pfl;
    m[7] = dw;
    m[8] = tot;
    s = 32'h0;
    for (int i = 0; i < t; i++)
      s += m[i];
    m[4] = -s;
    if (cnt > 0)
    begin
      for (int i = t; i < int'(tot) / 4; i++)
        m[i] = 32'h0;
      m[t] = cnt;
      m[t + 2] = 32'h1234_0000;
      for (int n = 0; n < cnt; n++)
      begin
        es = (n == hit) ? PS : PS ^ (32'h10 << n);
        m[t + 5 + 3 * n] = es;
        m[t + 6 + 3 * n] = efl;
        m[t + 7 + 3 * n] = m[4] + psig + pfl - es - efl;
      end
      s = 32'h0;
      for (int i = t; i < t + 5 + 3 * cnt; i++)
        s += m[i];
      m[t + 1] = -s;
    end
  endtask

  // Stream n words, start after hold cycles, judge the verdict flags
  task automatic go(input int n, input int hold, input logic [4:0] exp);
    int k;
    for (k = 0; k < 1024; k++)
      mic_loader_model_inst.mem[k] = m[k];
    fork
      mic_loader_model_inst.send(n, 5);
      begin
        repeat (hold) @(negedge mclk);
        // Idle checker never drains, so the buffer must refuse
        if (hold > 0)
          chk({4'h0, img_ready}, 5'h00);
        @(negedge mclk);
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        chk({4'h0, busy}, 5'h01);
        for (k = 0; k < 4000 && done !== 1'b1; k++)
          @(negedge mclk);
        // A verdict that never comes counts against the run
        if (k == 4000)
          n_mismatch++;
        chk({pass, err_sum, err_sig, err_plat, err_size}, exp);
        // Done lasts one cycle and the checker goes idle with it
        @(negedge mclk);
        chk({3'h0, done, busy}, 5'h00);
      end
    join
  endtask

  // Primary hit with full buffer first; reserved words hold filler
  task automatic t_primary();
    plat_id = 3'h1;
    build(PS, 32'h2, 32'd976, 32'd1024, 0, 0, 32'h0);
    go(256, 60, 5'h10);
  endtask

  // Every platform select against flags with junk above bit 7
  task automatic t_plat();
    build(PS, 32'hffff_ff5a, 32'd976, 32'd1024, 0, 0, 32'h0);
    for (int p = 0; p < 8; p++)
    begin
      plat_id = p[2:0];
      go(256, 0, (8'h5a >> p) & 8'h1 ? 5'h10 : 5'h02);
    end
  endtask

  // Sum, signature and size faults
  task automatic t_faults();
    plat_id = 3'h1;
    build(PS, 32'h2, 32'd976, 32'd1024, 0, 0, 32'h0);
    m[20] += 32'h1;
    go(256, 0, 5'h08);
    build(PS ^ 32'h0100_0000, 32'h2, 32'd976, 32'd1024, 0, 0, 32'h0);
    go(256, 0, 5'h04);
    build(PS, 32'h2, 32'd976, 32'd1000, 0, 0, 32'h0);
    go(9, 0, 5'h01);
    // Data size not a whole number of words
    build(PS, 32'h2, 32'd978, 32'd1024, 0, 0, 32'h0);
    go(9, 0, 5'h01);
  endtask

  // Extended table: hit in entry 2, then checksum and flag faults
  task automatic t_ext();
    plat_id = 3'h1;
    build(PS ^ 32'h1, 32'h2, 32'd400, 32'd1024, 3, 2, 32'h2);
    go(256, 0, 5'h10);
    m[114] += 32'h1;
    go(256, 0, 5'h08);
    m[114] -= 32'h2;
    m[119] += 32'h1;
    go(256, 0, 5'h08);
    build(PS ^ 32'h1, 32'h2, 32'd400, 32'd1024, 3, 2, 32'h1);
    go(256, 0, 5'h02);
    build(PS, 32'h2, 32'd400, 32'd1024, 2, 9, 32'h1);
    go(256, 0, 5'h10);
    build(PS ^ 32'h1, 32'h2, 32'd400, 32'd1024, 2, 9, 32'h2);
    go(256, 0, 5'h04);
  endtask

  // Zero data size means a 2000 byte payload and no table
  task automatic t_dzero();
    plat_id = 3'h1;
    build(PS, 32'h2, 32'h0, 32'd2048, 0, 0, 32'h0);
    go(512, 0, 5'h10);
  endtask

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    rstn = 1'b0;
    start = 1'b0;
    proc_sig = PS;
    plat_id = 3'h0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    // Idle outputs right after reset
    chk({busy, done, pass, err_sum, err_sig}, 5'h00);
    t_primary();
    t_plat();
    t_faults();
    t_ext();
    t_dzero();
    results();
  end

  // Watchdog: about 20 images of up to 700 cycles each
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
